// [core/isab_device.sv]
// Purpose: Slave end of the ISA bus: I/O map, shared memory, boot PROM.
// Assumes: Bus pins come from logic on ref_clk.
// Notes: Wait length and decode bases come from the package.
module isab_device
  import isab_pkg::*;
(
  isab_if.dev bus,
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slotStrap,
  output logic wideMode,
  output logic busRstQual,
  output logic accessDone
);
  logic slotWide_q;
  logic [19:0] addrHold_q;
  logic [19:0] addrLat;
  logic [5:0] rstCnt_q;
  logic rstQualHit;
  logic rstInt;
  isab_dev_state_t state_q;
  isab_dev_state_t state_d;
  logic [1:0] waitCnt_q;
  logic [15:0] regs [2**REG_AW];
  logic [15:0] mem [MEM_WORDS];
  logic [7:0] prom [PROM_BYTES];
  logic [15:0] rdData_q;
  logic oeLo_q;
  logic oeHi_q;
  logic accessDone_q;

  wire ioHit;
  wire laHit;
  wire memSelHi;
  wire memHit;
  wire promHit;
  wire memRdStb;
  wire memWrStb;
  wire ioRd;
  wire ioWr;
  wire memRd;
  wire memWr;
  wire promRd;
  wire promWr;
  wire anyRd;
  wire anyWr;
  wire rdActive;
  wire strobeIdle;
  wire wideXfer;
  wire hiLane;
  wire startAcc;
  wire lastDone;
  wire [REG_AW-1:0] regIdx;
  wire [7:0] memIdx;
  wire [PROM_AW-1:0] promIdx;
  wire [15:0] rdWord;
  wire [7:0] rdByte;
  wire [15:0] rdData_d;
  wire wrLo;
  wire wrHi;
  wire [7:0] wrHiByte;

  // Slot width strap; unconnected pin reads low, so 8-bit by default
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      slotWide_q <= slotStrap;
    end
  end

  // Transparent while the latch strobe is high, frozen after its fall
  always_ff @(posedge ref_clk) begin
    if (bus.ale) begin
      addrHold_q <= bus.sa;
    end
  end
  assign addrLat = bus.ale ? bus.sa : addrHold_q;

  // Short glitches on the bus reset must not wipe the device
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !bus.busReset) begin
      rstCnt_q <= 6'h00;
    end else if (!rstQualHit) begin
      rstCnt_q <= rstCnt_q + 6'h01;
    end
  end
  assign rstQualHit = rstCnt_q == RST_QUAL;
  assign rstInt = !rst_n || rstQualHit;

  // Decoders
  assign ioHit =
    addrLat[19:IO_SEL_LSB] == IO_BASE[19:IO_SEL_LSB];
  assign laHit = bus.la == MEM_LA_BASE;
  // An 8-bit slot has no high lines, so fall back on the low ones
  assign memSelHi = slotWide_q ? laHit :
                    addrLat[19:17] == MEM_LA_BASE[2:0];
  assign memHit = memSelHi &&
    addrLat[16:MEM_BYTE_AW] == '0;
  assign promHit =
    addrLat[19:PROM_AW] == PROM_BASE[19:PROM_AW];
  assign memRdStb = slotWide_q ? !bus.mem_read_strobe_n :
                    !bus.low_mem_read_n;
  assign memWrStb = slotWide_q ? !bus.mem_write_strobe_n :
                    !bus.low_mem_write_n;
  assign ioRd = !bus.io_read_strobe_n && ioHit;
  assign ioWr = !bus.io_write_strobe_n && ioHit;
  assign memRd = memRdStb && memHit && !promHit;
  assign memWr = memWrStb && memHit && !promHit;
  assign promRd = !bus.low_mem_read_n && promHit;
  assign promWr = !bus.low_mem_write_n && promHit;
  assign anyRd = ioRd || memRd || promRd;
  assign anyWr = ioWr || memWr || promWr;
  assign rdActive = !bus.io_read_strobe_n || !bus.mem_read_strobe_n ||
                    !bus.low_mem_read_n;
  assign strobeIdle = !rdActive && bus.io_write_strobe_n &&
                      bus.mem_write_strobe_n && bus.low_mem_write_n;
  assign wideXfer = slotWide_q && !bus.byte_high_enable_n &&
                    !addrLat[0] && !promHit;
  assign hiLane = slotWide_q && !bus.byte_high_enable_n &&
                  addrLat[0] && !promHit;
  assign regIdx = addrLat[REG_AW:1];
  assign memIdx = addrLat[MEM_BYTE_AW-1:1];
  assign promIdx = addrLat[PROM_AW-1:0];

  // Width acknowledges come straight from address decode
  assign bus.wide_io_ack_n = !(slotWide_q && ioHit);
  assign bus.wide_mem_ack_n = !(slotWide_q && laHit);

  // Access sequencing
  assign startAcc = state_q == ISAB_D_IDLE && (anyRd || anyWr);
  assign lastDone = state_q == ISAB_D_WAIT && waitCnt_q == 2'h0;
  // Ready drops in the strobe's first cycle so no edge is missed
  assign bus.channel_ready_out =
    !(state_q == ISAB_D_WAIT || startAcc);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ISAB_D_IDLE: begin
        if (startAcc) begin
          state_d = ISAB_D_WAIT;
        end
      end
      ISAB_D_WAIT: begin
        if (waitCnt_q == 2'h0) begin
          state_d = ISAB_D_HOLD;
        end
      end
      ISAB_D_HOLD: begin
        if (strobeIdle) begin
          state_d = ISAB_D_IDLE;
        end
      end
      default: begin
        state_d = ISAB_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rstInt) begin
      state_q <= ISAB_D_IDLE;
      waitCnt_q <= WAIT_LOAD;
    end else begin
      state_q <= state_d;
      waitCnt_q <= (state_q == ISAB_D_WAIT) ?
                   waitCnt_q - 2'h1 : WAIT_LOAD;
    end
  end

  // Read path
  assign rdWord = ioRd ? regs[regIdx] :
                  promRd ? {8'h00, prom[promIdx]} : mem[memIdx];
  assign rdByte = (addrLat[0] && !promHit) ? rdWord[15:8] :
                  rdWord[7:0];
  assign rdData_d = (wideXfer || hiLane) ? rdWord :
                    {8'h00, rdByte};

  always_ff @(posedge ref_clk) begin
    if (rstInt) begin
      rdData_q <= 16'h0000;
      oeLo_q <= 1'b0;
      oeHi_q <= 1'b0;
    end else if (lastDone) begin
      rdData_q <= rdData_d;
      oeLo_q <= anyRd && !hiLane;
      oeHi_q <= anyRd && (wideXfer || hiLane);
    end else if (state_q != ISAB_D_HOLD) begin
      oeLo_q <= 1'b0;
      oeHi_q <= 1'b0;
    end
  end
  // Gating by the live strobe avoids a clash on the next cycle
  assign bus.devSd = rdData_q;
  assign bus.devSdOeLo = oeLo_q && rdActive;
  assign bus.devSdOeHi = oeHi_q && rdActive;

  // Write path; an odd byte in an 8-bit slot arrives on the low lane
  assign wrLo = !addrLat[0];
  assign wrHi = addrLat[0] || wideXfer;
  assign wrHiByte = (wideXfer || hiLane) ? bus.sd[15:8] :
                    bus.sd[7:0];

  generate
    for (genvar i = 0; i < 2**REG_AW; i++) begin : gRegs
      always_ff @(posedge ref_clk) begin
        if (rstInt) begin
          regs[i] <= 16'h0000;
        end else if (lastDone && ioWr && regIdx == i) begin
          if (wrLo) begin
            regs[i][7:0] <= bus.sd[7:0];
          end
          if (wrHi) begin
            regs[i][15:8] <= wrHiByte;
          end
        end
      end
    end
  endgenerate

  // Memories are not cleared by reset, as in a real RAM
  always_ff @(posedge ref_clk) begin
    if (lastDone && memWr) begin
      if (wrLo) begin
        mem[memIdx][7:0] <= bus.sd[7:0];
      end
      if (wrHi) begin
        mem[memIdx][15:8] <= wrHiByte;
      end
    end
    if (lastDone && promWr) begin
      prom[promIdx] <= bus.sd[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rstInt) begin
      accessDone_q <= 1'b0;
    end else begin
      accessDone_q <= lastDone;
    end
  end

  assign wideMode = slotWide_q;
  assign busRstQual = rstQualHit;
  assign accessDone = accessDone_q;
endmodule

// [core/isab_pkg.sv]
// Purpose: Shared constants and types of the ISA slave bus pair.
// Assumes: Both ends run on ref_clk at 100 MHz.
// Notes: Decode bases and window sizes are fixed here.
package isab_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_MIN_NS = 400;
  // Reset must last longer than the minimum, hence one extra cycle
  localparam int RST_QUAL_CYC =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam logic [5:0] RST_QUAL = 6'(RST_QUAL_CYC);
  localparam int WAIT_NS = 30;
  localparam int WAIT_CYC = WAIT_NS / CLK_PERIOD_NS;
  localparam logic [1:0] WAIT_LOAD = 2'(WAIT_CYC - 1);
  localparam logic [1:0] STB_MIN = 2'h1;

  localparam logic [19:0] IO_BASE = 20'h00300;
  localparam int IO_SEL_LSB = 5;
  localparam int REG_AW = 4;
  localparam logic [6:0] MEM_LA_BASE = 7'h68;
  localparam int MEM_BYTE_AW = 9;
  localparam int MEM_WORDS = 256;
  localparam logic [19:0] PROM_BASE = 20'hc8000;
  localparam int PROM_AW = 5;
  localparam int PROM_BYTES = 32;
  localparam logic [3:0] LOW_MEG = 4'h0;

  typedef enum logic [2:0] {
    ISAB_D_IDLE = 3'b001,
    ISAB_D_WAIT = 3'b010,
    ISAB_D_HOLD = 3'b100
  } isab_dev_state_t;

  typedef enum logic [2:0] {
    ISAB_H_IDLE = 3'b001,
    ISAB_H_ADDR = 3'b010,
    ISAB_H_STB = 3'b100
  } isab_host_state_t;
endpackage

// [core/isab_if.sv]
// Purpose: Pin bundle between the bus master and the slave device.
// Assumes: Data lines float high when nobody drives them.
// Notes: The resolved data level is worked out here from the enables.
interface isab_if;
  logic [19:0] sa;
  logic [6:0] la;
  logic ale;
  logic byte_high_enable_n;
  logic io_read_strobe_n;
  logic io_write_strobe_n;
  logic mem_read_strobe_n;
  logic mem_write_strobe_n;
  logic low_mem_read_n;
  logic low_mem_write_n;
  logic busReset;
  logic [15:0] hostSd;
  logic hostSdOe;
  logic [15:0] devSd;
  logic devSdOeLo;
  logic devSdOeHi;
  logic wide_io_ack_n;
  logic wide_mem_ack_n;
  logic channel_ready_out;
  logic [15:0] sd;

  assign sd[7:0] = devSdOeLo ? devSd[7:0] :
                   hostSdOe ? hostSd[7:0] : 8'hff;
  assign sd[15:8] = devSdOeHi ? devSd[15:8] :
                    hostSdOe ? hostSd[15:8] : 8'hff;

  modport dev (
    input sa, la, ale, byte_high_enable_n,
    input io_read_strobe_n, io_write_strobe_n,
    input mem_read_strobe_n, mem_write_strobe_n,
    input low_mem_read_n, low_mem_write_n, busReset, sd,
    output devSd, devSdOeLo, devSdOeHi,
    output wide_io_ack_n, wide_mem_ack_n, channel_ready_out
  );
  modport host (
    output sa, la, ale, byte_high_enable_n,
    output io_read_strobe_n, io_write_strobe_n,
    output mem_read_strobe_n, mem_write_strobe_n,
    output low_mem_read_n, low_mem_write_n, busReset,
    output hostSd, hostSdOe,
    input sd, wide_io_ack_n, wide_mem_ack_n, channel_ready_out
  );
endinterface

// [core/isab_host.sv]
// Purpose: Bus master end: runs one I/O or memory cycle per command.
// Assumes: Device answers on ref_clk; ready is sampled after the minimum.
// Notes: Low memory strobes follow addresses below one megabyte.
module isab_host
  import isab_pkg::*;
(
  isab_if.host bus,
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic cmdIo,
  input wire logic [23:0] cmdAddr,
  input wire logic cmdWide,
  input wire logic [15:0] cmdData,
  input wire logic hostBusReset,
  output logic cmdReady,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspWideIo,
  output logic rspWideMem
);
  isab_host_state_t state_q;
  isab_host_state_t state_d;
  logic [23:0] addr_q;
  logic write_q;
  logic io_q;
  logic wide_q;
  logic [15:0] data_q;
  logic [1:0] cnt_q;
  logic busRst_q;
  logic rspValid_q;
  logic [15:0] rspData_q;
  logic rspWideIo_q;
  logic rspWideMem_q;

  wire stb;
  wire lowMeg;
  wire take;
  wire done;

  assign take = state_q == ISAB_H_IDLE && cmdValid;
  assign stb = state_q == ISAB_H_STB;
  assign lowMeg = addr_q[23:20] == LOW_MEG;
  assign done = stb && cnt_q == STB_MIN && bus.channel_ready_out;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ISAB_H_IDLE: begin
        if (cmdValid) begin
          state_d = ISAB_H_ADDR;
        end
      end
      ISAB_H_ADDR: begin
        state_d = ISAB_H_STB;
      end
      ISAB_H_STB: begin
        if (done) begin
          state_d = ISAB_H_IDLE;
        end
      end
      default: begin
        state_d = ISAB_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ISAB_H_IDLE;
      cnt_q <= 2'h0;
      busRst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busRst_q <= hostBusReset;
      cnt_q <= (stb && cnt_q != STB_MIN) ? cnt_q + 2'h1 :
               (stb ? cnt_q : 2'h0);
    end
  end

  // Address stays put for the whole cycle, across the latch fall
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      addr_q <= 24'h000000;
      write_q <= 1'b0;
      io_q <= 1'b0;
      wide_q <= 1'b0;
      data_q <= 16'h0000;
    end else if (take) begin
      addr_q <= cmdAddr;
      write_q <= cmdWrite;
      io_q <= cmdIo;
      wide_q <= cmdWide;
      data_q <= cmdData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rspValid_q <= 1'b0;
      rspData_q <= 16'h0000;
      rspWideIo_q <= 1'b0;
      rspWideMem_q <= 1'b0;
    end else begin
      rspValid_q <= done;
      if (done) begin
        rspData_q <= write_q ? data_q : bus.sd;
        rspWideIo_q <= !bus.wide_io_ack_n;
        rspWideMem_q <= !bus.wide_mem_ack_n;
      end
    end
  end

  assign bus.sa = addr_q[19:0];
  assign bus.la = addr_q[23:17];
  assign bus.ale = state_q == ISAB_H_ADDR;
  assign bus.byte_high_enable_n = !wide_q;
  assign bus.io_read_strobe_n = !(stb && io_q && !write_q);
  assign bus.io_write_strobe_n = !(stb && io_q && write_q);
  assign bus.mem_read_strobe_n = !(stb && !io_q && !write_q);
  assign bus.mem_write_strobe_n =
    !(stb && !io_q && write_q);
  assign bus.low_mem_read_n = !(stb && !io_q && !write_q && lowMeg);
  assign bus.low_mem_write_n = !(stb && !io_q && write_q && lowMeg);
  assign bus.busReset = busRst_q;
  assign bus.hostSd = data_q;
  assign bus.hostSdOe = stb && write_q;

  assign cmdReady = state_q == ISAB_H_IDLE;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign rspWideIo = rspWideIo_q;
  assign rspWideMem = rspWideMem_q;
endmodule

// [tb/isab_chk_assertions.sv]
// Purpose: Pin-level checks between the bus master and the slave.
// Assumes: One clock; rst_n synchronous and active low.
// Notes: The wait length of three cycles is the device's fixed choice.
module isab_chk
  import isab_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [19:0] sa,
  input wire logic [6:0] la,
  input wire logic ale,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic low_mem_read_n,
  input wire logic low_mem_write_n,
  input wire logic devSdOeLo,
  input wire logic devSdOeHi,
  input wire logic wide_io_ack_n,
  input wire logic wide_mem_ack_n,
  input wire logic channel_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire anyRd = !io_read_strobe_n || !mem_read_strobe_n || !low_mem_read_n;
  wire anyWr = !io_write_strobe_n || !mem_write_strobe_n || !low_mem_write_n;
  wire anyStb = anyRd || anyWr;
  a_drive_in_read: assert property (
    (devSdOeLo || devSdOeHi) |-> anyRd)
    else $error("data lines driven outside a read");
  // Ready drops in the strobe's first cycle, then three wait cycles
  a_wait_length: assert property (
    $fell(channel_ready_out) |-> !channel_ready_out[*4] ##1 channel_ready_out)
    else $error("wait length wrong");
  a_wait_has_cause: assert property (
    $fell(channel_ready_out) |-> anyStb)
    else $error("wait without a strobe");
  a_wide_io_lanes: assert property (
    !io_read_strobe_n && !wide_io_ack_n && devSdOeLo |-> devSdOeHi)
    else $error("wide io read not on both lanes");
  a_mem_ack_high: assert property (
    $stable(la) |-> $stable(wide_mem_ack_n))
    else $error("wide memory ack moved without high address");
  a_addr_held: assert property (
    $fell(ale) |-> $stable(la) && $stable(sa))
    else $error("address moved at latch fall");
  a_latch_then_stb: assert property (
    $rose(ale) |=> !ale && anyStb)
    else $error("latch pulse not followed by strobe");
  a_low_rd_range: assert property (
    !low_mem_read_n |-> !mem_read_strobe_n && la[6:3] == 4'h0)
    else $error("low read strobe outside low range");
  a_low_wr_range: assert property (
    !low_mem_write_n |-> !mem_write_strobe_n && la[6:3] == 4'h0)
    else $error("low write strobe outside low range");
  a_io_wr_width: assert property (
    $fell(io_write_strobe_n) |=> !io_write_strobe_n)
    else $error("io write strobe too short");
  cover property ($fell(channel_ready_out));
  cover property (!wide_io_ack_n && devSdOeHi);
  cover property (!low_mem_write_n);
  cover property (devSdOeHi && !devSdOeLo);
endmodule

// [tb/isa_slave_bus_interface_tb_top.sv]
// Purpose: Runs host commands against the device and checks results.
// Assumes: Undriven data lanes read as ff.
// Notes: Bus reset pulses are sized around the 41-cycle threshold.
module isa_slave_bus_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slotStrap = 1'b1;
  logic cmdValid = 1'b0, cmdWrite = 1'b0, cmdIo = 1'b0, cmdWide = 1'b0;
  logic [23:0] cmdAddr = 24'h0;
  logic [15:0] cmdData = 16'h0;
  logic hostBusReset = 1'b0;
  logic wideMode, busRstQual, accessDone, cmdReady, rspValid;
  logic rspWideIo, rspWideMem;
  logic [15:0] rspData;
  logic qualSeen = 1'b0;
  int doneCnt = 0;
  int failures = 0;
  int checks = 0;
  isab_if u_isab_if();
  isab_device u_isab_device(.bus(u_isab_if), .ref_clk(ref_clk),
    .rst_n(rst_n), .slotStrap(slotStrap), .wideMode(wideMode),
    .busRstQual(busRstQual), .accessDone(accessDone));
  isab_host u_isab_host(.bus(u_isab_if), .ref_clk(ref_clk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdIo(cmdIo),
    .cmdAddr(cmdAddr), .cmdWide(cmdWide), .cmdData(cmdData),
    .hostBusReset(hostBusReset), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .rspWideIo(rspWideIo),
    .rspWideMem(rspWideMem));
  isab_chk u_isab_chk(.ref_clk(ref_clk), .rst_n(rst_n),
    .sa(u_isab_if.sa), .la(u_isab_if.la), .ale(u_isab_if.ale),
    .io_read_strobe_n(u_isab_if.io_read_strobe_n),
    .io_write_strobe_n(u_isab_if.io_write_strobe_n),
    .mem_read_strobe_n(u_isab_if.mem_read_strobe_n),
    .mem_write_strobe_n(u_isab_if.mem_write_strobe_n),
    .low_mem_read_n(u_isab_if.low_mem_read_n),
    .low_mem_write_n(u_isab_if.low_mem_write_n),
    .devSdOeLo(u_isab_if.devSdOeLo), .devSdOeHi(u_isab_if.devSdOeHi),
    .wide_io_ack_n(u_isab_if.wide_io_ack_n),
    .wide_mem_ack_n(u_isab_if.wide_mem_ack_n),
    .channel_ready_out(u_isab_if.channel_ready_out));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (busRstQual === 1'b1) qualSeen <= 1'b1;
  end
  always @(posedge ref_clk) begin
    if (accessDone === 1'b1) doneCnt <= doneCnt + 1;
  end
  function automatic logic [15:0] ioVal(input int i);
    return 16'h5a0f ^ 16'(i * 32'h1111);
  endfunction
  function automatic logic [23:0] memAt(input int i);
    return 24'hd00000 + 24'(i) * 24'h0000aa;
  endfunction
  function automatic logic [23:0] promAt(input int i);
    return 24'h0c8001 + 24'(i) * 24'h00000a;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One command; bounded wait, since a lost answer must not hang the run
  task automatic xfer(input logic w, io, wd, input logic [23:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    cmdWrite <= w;
    cmdIo <= io;
    cmdWide <= wd;
    cmdAddr <= a;
    cmdData <= d;
    cmdValid <= 1'b1;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rspValid !== 1'b1 && n < 40);
    chk("rspValid", {15'h0, rspValid}, 16'h1);
    chk("cmdReady", {15'h0, cmdReady}, 16'h1);
  endtask
  task automatic rd(input logic io, wd, input logic [23:0] a,
    input logic [15:0] exp, input string what);
    xfer(1'b0, io, wd, a, 16'h0);
    chk(what, rspData, exp);
  endtask
  task automatic resetDut(input logic strap);
    slotStrap <= strap;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge ref_clk);
    failures++;
    end_sim;
  end
  initial begin
    resetDut(1'b1);
    chk("wideMode", {15'h0, wideMode}, 16'h1);
    for (int i = 0; i < 16; i++) begin
      xfer(1, 1, 1, 24'h300 + 24'(2 * i), ioVal(i));
    end
    for (int i = 0; i < 16; i++) begin
      rd(1, 1, 24'h300 + 24'(2 * i), ioVal(i), "ioReg");
      chk("wideIo", {15'h0, rspWideIo}, 16'h1);
    end
    xfer(1, 1, 1, 24'h305, 16'hc300);
    rd(1, 1, 24'h305, 16'hc3ff, "hiLane");
    rd(1, 1, 24'h3a0, 16'hffff, "unmapped");
    chk("accessDone", 16'(doneCnt), 16'h0022);
    $display("test io done");
    for (int i = 0; i < 4; i++) begin
      xfer(1, 0, 1, memAt(i), ~ioVal(i));
    end
    for (int i = 0; i < 4; i++) begin
      rd(0, 1, memAt(i), ~ioVal(i), "mem");
      chk("wideMem", {15'h0, rspWideMem}, 16'h1);
    end
    rd(0, 1, 24'hd00200, 16'hffff, "memOut");
    $display("test mem done");
    for (int i = 0; i < 4; i++) begin
      xfer(1, 0, 0, promAt(i), 16'(8'h3c + i));
    end
    for (int i = 0; i < 4; i++) begin
      rd(0, 0, promAt(i), {8'hff, 8'(8'h3c + i)}, "prom");
    end
    $display("test prom done");
    hostBusReset <= 1'b1;
    repeat (isab_pkg::RST_QUAL_CYC - 1) @(posedge ref_clk);
    hostBusReset <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk("shortReset", {15'h0, qualSeen}, 16'h0);
    rd(1, 1, 24'h300, ioVal(0), "keptReg");
    hostBusReset <= 1'b1;
    repeat (isab_pkg::RST_QUAL_CYC + 5) @(posedge ref_clk);
    chk("busRstQual", {15'h0, busRstQual}, 16'h1);
    hostBusReset <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rd(1, 1, 24'h300, 16'h0, "clearedReg");
    rd(0, 1, memAt(0), ~ioVal(0), "keptMem");
    $display("test busreset done");
    resetDut(1'b0);
    chk("wideMode", {15'h0, wideMode}, 16'h0);
    xfer(1, 1, 0, 24'h302, 16'h0077);
    rd(1, 0, 24'h302, 16'hff77, "byteIo");
    chk("wideIo", {15'h0, rspWideIo}, 16'h0);
    rd(0, 0, 24'hd00000, 16'hffff, "fullStb");
    xfer(1, 0, 0, 24'h000003, 16'h00a5);
    rd(0, 0, 24'h000003, 16'hffa5, "lowMem");
    xfer(1, 0, 0, 24'h0c8005, 16'h0096);
    rd(0, 0, 24'h0c8005, 16'hff96, "lowProm");
    $display("test narrow done");
    end_sim;
  end
endmodule
